// ---- rtl/pram_defines.vh ----
/*
 * constants for the parameterised ram block: variant codes, default sizes,
 * register offsets, field positions and reset values of the control bus.
 * assumes it is included by its bare name from the design files.
 */
`ifndef PRAM_DEFINES_VH
`define PRAM_DEFINES_VH

// variant codes
`define PRAM_VAR_ASYNC 2'h0
`define PRAM_VAR_SYNC 2'h1
`define PRAM_VAR_DUAL 2'h2

// size limits and defaults
`define PRAM_DEPTH_DEFAULT 16
`define PRAM_DEPTH_MIN 16
`define PRAM_DEPTH_MAX 256
`define PRAM_DEPTH_STEP 16
`define PRAM_WIDTH_DEFAULT 16
`define PRAM_WIDTH_MIN 1
`define PRAM_WIDTH_MAX 64

// register byte offsets
`define PRAM_REG_CTRL 8'h00
`define PRAM_REG_SW_ADDR 8'h04
`define PRAM_REG_WDATA_LO 8'h08
`define PRAM_REG_WDATA_HI 8'h0C
`define PRAM_REG_CMD 8'h10
`define PRAM_REG_RDATA_LO 8'h14
`define PRAM_REG_RDATA_HI 8'h18
`define PRAM_REG_STATUS 8'h1C
`define PRAM_REG_CONFIG 8'h20

// field positions
`define PRAM_CTRL_LOCK_BIT 0
`define PRAM_CMD_WRITE_BIT 0
`define PRAM_STAT_RANGE_BIT 31
`define PRAM_CFG_WIDTH_LSB 16
`define PRAM_CFG_VAR_LSB 24

// reset values and responses
`define PRAM_CTRL_RESET 1'h0
`define PRAM_RESP_OKAY 2'h0
`define PRAM_RESP_SLVERR 2'h2

`endif

// ---- rtl/pram_sync2.v ----
/*
 * two flip-flop synchroniser, parameterised width.
 * assumes the inputs are asynchronous to ref_clk; the first stage feeds
 * only the second.
 */
`timescale 1ns/10ps

module pram_sync2 #(
    parameter WIDTH = 1
) (
    // clock
    input wire ref_clk,
    // data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

// two stages, no reset so a metastable first stage is never gated
always @(posedge ref_clk) begin
    stage1 <= async_in;
    sync_out <= stage1;
end

endmodule

// ---- rtl/pram_top.v ----
/*
 * parameterised distributed ram in three variants with an axi4-lite
 * window for software access, lock control and status.
 * assumes user pins (address, data, write enable, write clock) are
 * asynchronous to ref_clk and are synchronised here.
 */
// Function
// - build as asynchronous, synchronous or dual-port ram by parameter
// - depth multiple of 16 from 16 to 256, default 16
// - word width parameter from 1 to 64 bits
// - address ports are log2 of depth bits wide
// - async variant stores and presents the input word while enable high
// - enable low leaves memory unchanged and ignores write data
// - clocked variants write only on rising write clock with enable high
// - clocked write shows the new word on the primary output afterwards
// - primary output always shows word at the address input
// - dual-port variant has two address/output pairs on one storage
// - secondary output follows the secondary address, not the write clock
// - in dual-port the primary output is the single-port output
// - optional power-up preload, readable and overwritable
// - without preload contents are undefined; preload is optional
`timescale 1ns/10ps
`include "pram_defines.vh"

module pram_top #(
    parameter VARIANT = `PRAM_VAR_SYNC,
    parameter DEPTH = `PRAM_DEPTH_DEFAULT,
    parameter WORD_WIDTH = `PRAM_WIDTH_DEFAULT,
    parameter USE_INIT = 0,
    parameter [63:0] INIT_FILL = 64'h0000000000000000
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // user ram pins
    input wire [pram_clog2(DEPTH)-1:0] ram_address,
    input wire [WORD_WIDTH-1:0] write_data_in,
    input wire write_enable,
    input wire write_clock,
    input wire [pram_clog2(DEPTH)-1:0] secondary_read_address,
    output reg [WORD_WIDTH-1:0] single_port_read_out,
    output reg [WORD_WIDTH-1:0] secondary_read_out,
    // axi4-lite write channels
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read channels
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

// ceiling log2, used for the address port widths
function integer pram_clog2;
    input integer value;
    integer i;
    begin
        pram_clog2 = 0;
        for (i = value - 1; i > 0; i = i >> 1) begin
            pram_clog2 = pram_clog2 + 1;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// sizing
localparam AW = pram_clog2(DEPTH);
// illegal depths fall back to the default size rather than half-build
localparam DEPTH_OK = (DEPTH >= `PRAM_DEPTH_MIN) && (DEPTH <= `PRAM_DEPTH_MAX) &&
    (DEPTH % `PRAM_DEPTH_STEP == 0);
localparam DEPTH_EFF = DEPTH_OK ? DEPTH : `PRAM_DEPTH_DEFAULT;
localparam [AW:0] DEPTH_LIM = DEPTH_EFF[AW:0];
localparam [8:0] CFG_DEPTH = DEPTH_EFF[8:0];
localparam [6:0] CFG_WIDTH = WORD_WIDTH[6:0];
localparam [1:0] VAR_CODE = VARIANT[1:0];
localparam IS_ASYNC = (VAR_CODE == `PRAM_VAR_ASYNC);
localparam IS_DUAL = (VAR_CODE == `PRAM_VAR_DUAL);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
wire [AW-1:0] addr_s;
wire [AW-1:0] sec_addr_s;
wire [WORD_WIDTH-1:0] wdata_s;
wire wen_s;
wire wclk_s;
reg wclk_prev;

// every user pin is asynchronous, so all pass two flops before use
pram_sync2 #(.WIDTH(2 * AW + WORD_WIDTH + 2)) u_pin_sync (
    .ref_clk(ref_clk),
    .async_in({ram_address, secondary_read_address, write_data_in, write_enable,
        write_clock}),
    .sync_out({addr_s, sec_addr_s, wdata_s, wen_s, wclk_s})
);

// write clock edge detect on the synchronised level
always @(posedge ref_clk) begin
    if (rst) begin
        wclk_prev <= 1'b0;
    end else begin
        wclk_prev <= wclk_s;
    end
end
wire wclk_rise = wclk_s & ~wclk_prev;
////////////////////////////////////////////////////////////////////////////
// software control registers
reg ctrl_lock;
reg [AW-1:0] sw_addr;
reg [31:0] sw_wdata_lo;
reg [31:0] sw_wdata_hi;
reg sw_write_pend;
reg range_error;
reg [AW-1:0] last_write_addr;
reg [15:0] write_count;

////////////////////////////////////////////////////////////////////////////
// storage and write path
reg [WORD_WIDTH-1:0] mem [0:DEPTH_EFF-1];
integer k;

// optional power-up fill; with it off the words start undefined
initial begin
    if (USE_INIT != 0) begin
        for (k = 0; k < DEPTH_EFF; k = k + 1) begin
            mem[k] = INIT_FILL[WORD_WIDTH-1:0];
        end
    end
end

// async writes every cycle the enable level is high; clocked ones on the edge
wire user_strobe = IS_ASYNC ? wen_s : (wen_s & wclk_rise);
wire user_write = user_strobe & ~ctrl_lock;
wire user_in_range = ({1'b0, addr_s} < DEPTH_LIM);
wire sw_in_range = ({1'b0, sw_addr} < DEPTH_LIM);
// user writes win the port; a software write waits one free cycle
wire sw_write = sw_write_pend & ~user_write;
wire [63:0] sw_word = {sw_wdata_hi, sw_wdata_lo};

// stored words are never reset
always @(posedge ref_clk) begin
    if (user_write && user_in_range) begin
        mem[addr_s] <= wdata_s;
    end else if (sw_write && sw_in_range) begin
        mem[sw_addr] <= sw_word[WORD_WIDTH-1:0];
    end
end

// read words with out-of-range locations forced to zero
wire [WORD_WIDTH-1:0] prim_word = user_in_range ? mem[addr_s] : {WORD_WIDTH{1'b0}};
wire [WORD_WIDTH-1:0] sec_word =
    ({1'b0, sec_addr_s} < DEPTH_LIM) ? mem[sec_addr_s] : {WORD_WIDTH{1'b0}};
wire [WORD_WIDTH-1:0] sw_rd_word = sw_in_range ? mem[sw_addr] : {WORD_WIDTH{1'b0}};

// output flops; async writes bypass so the input shows at once
always @(posedge ref_clk) begin
    if (rst) begin
        single_port_read_out <= {WORD_WIDTH{1'b0}};
        secondary_read_out <= {WORD_WIDTH{1'b0}};
    end else begin
        single_port_read_out <= (IS_ASYNC && user_write && user_in_range) ? wdata_s :
            prim_word;
        // secondary port ignores the write clock entirely
        secondary_read_out <= IS_DUAL ? sec_word : {WORD_WIDTH{1'b0}};
    end
end
// status bookkeeping; a new range error beats a same-cycle clear
wire any_write = user_write | sw_write;
wire bad_write = (user_write & ~user_in_range) | (sw_write & ~user_write & ~sw_in_range);
reg status_clear;
always @(posedge ref_clk) begin
    if (rst) begin
        range_error <= 1'b0;
        last_write_addr <= {AW{1'b0}};
        write_count <= 16'h0000;
    end else begin
        if (bad_write) begin
            range_error <= 1'b1;
        end else if (status_clear) begin
            range_error <= 1'b0;
        end
        if (any_write) begin
            last_write_addr <= user_write ? addr_s : sw_addr;
            write_count <= write_count + 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// axi4-lite write side
reg aw_have;
reg w_have;
reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;

assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
assign s_axi_wready = ~w_have & ~s_axi_bvalid;

wire wr_go = aw_have & w_have & ~s_axi_bvalid;
wire [31:0] bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
    {8{w_strb_q[0]}}};
wire wr_mapped = (aw_addr_q == `PRAM_REG_CTRL) || (aw_addr_q == `PRAM_REG_SW_ADDR) ||
    (aw_addr_q == `PRAM_REG_WDATA_LO) || (aw_addr_q == `PRAM_REG_WDATA_HI) ||
    (aw_addr_q == `PRAM_REG_CMD) || (aw_addr_q == `PRAM_REG_STATUS);

// address and data taken in either order; payload flops skip reset, read only on wr_go
always @(posedge ref_clk) begin
    if (rst) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PRAM_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `PRAM_RESP_OKAY : `PRAM_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// register updates on the accepted write
wire [31:0] ctrl_new = ({31'h0, ctrl_lock} & ~bmask) | (w_data_q & bmask);
wire [31:0] addr_new = ({{(32 - AW){1'b0}}, sw_addr} & ~bmask) | (w_data_q & bmask);
wire cmd_hit = wr_go && (aw_addr_q == `PRAM_REG_CMD) && w_strb_q[0] &&
    w_data_q[`PRAM_CMD_WRITE_BIT];

always @(posedge ref_clk) begin
    if (rst) begin
        ctrl_lock <= `PRAM_CTRL_RESET;
        sw_addr <= {AW{1'b0}};
        sw_wdata_lo <= 32'h00000000;
        sw_wdata_hi <= 32'h00000000;
        sw_write_pend <= 1'b0;
    end else begin
        if (wr_go && aw_addr_q == `PRAM_REG_CTRL) begin
            ctrl_lock <= ctrl_new[`PRAM_CTRL_LOCK_BIT];
        end
        if (wr_go && aw_addr_q == `PRAM_REG_SW_ADDR) begin
            sw_addr <= addr_new[AW-1:0];
        end
        if (wr_go && aw_addr_q == `PRAM_REG_WDATA_LO) begin
            sw_wdata_lo <= (sw_wdata_lo & ~bmask) | (w_data_q & bmask);
        end
        if (wr_go && aw_addr_q == `PRAM_REG_WDATA_HI) begin
            sw_wdata_hi <= (sw_wdata_hi & ~bmask) | (w_data_q & bmask);
        end
        if (cmd_hit) begin
            sw_write_pend <= 1'b1;
        end else if (sw_write) begin
            sw_write_pend <= 1'b0;
        end
    end
end

// write-one-to-clear of the range error flag
always @* begin
    status_clear = wr_go && (aw_addr_q == `PRAM_REG_STATUS) && w_strb_q[3] &&
        w_data_q[`PRAM_STAT_RANGE_BIT];
end

////////////////////////////////////////////////////////////////////////////
// axi4-lite read side
reg [63:0] sw_rword;
reg [31:0] rd_mux;
reg rd_mapped;

// widen the addressed word to 64 bits for the two read halves
always @* begin
    sw_rword = 64'h0000000000000000;
    sw_rword[WORD_WIDTH-1:0] = sw_rd_word;
end

// read decode; unmapped addresses read zero with an error response
always @* begin
    rd_mux = 32'h00000000;
    rd_mapped = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
        `PRAM_REG_CTRL: rd_mux = {31'h0, ctrl_lock};
        `PRAM_REG_SW_ADDR: rd_mux = {{(32 - AW){1'b0}}, sw_addr};
        `PRAM_REG_WDATA_LO: rd_mux = sw_wdata_lo;
        `PRAM_REG_WDATA_HI: rd_mux = sw_wdata_hi;
        `PRAM_REG_CMD: rd_mux = {31'h0, sw_write_pend};
        `PRAM_REG_RDATA_LO: rd_mux = sw_rword[31:0];
        `PRAM_REG_RDATA_HI: rd_mux = sw_rword[63:32];
        `PRAM_REG_STATUS: rd_mux = {range_error, 7'h00, write_count, 8'h00} |
            {{(32 - AW){1'b0}}, last_write_addr};
        `PRAM_REG_CONFIG: rd_mux = {6'h00, VAR_CODE, 1'b0, CFG_WIDTH, 7'h00, CFG_DEPTH};
        default: rd_mapped = 1'b0;
    endcase
end

assign s_axi_arready = ~s_axi_rvalid;

// one read in flight; data held until rready
always @(posedge ref_clk) begin
    if (rst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PRAM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_mapped ? `PRAM_RESP_OKAY : `PRAM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

// ---- verif/pram_top_asserts.sv ----
/* checker for pram_top: pin-to-output timing and axi handshakes.
   assumes it is bound to pram_top and user pins stay put across write pulses. */
`timescale 1ns/10ps
module pram_top_asserts #(
    parameter DEPTH = 16,
    parameter WORD_WIDTH = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // user pins
    input wire [$clog2(DEPTH)-1:0] ram_address,
    input wire [$clog2(DEPTH)-1:0] secondary_read_address,
    input wire [WORD_WIDTH-1:0] write_data_in,
    input wire write_enable,
    input wire write_clock,
    input wire [WORD_WIDTH-1:0] single_port_read_out,
    input wire [WORD_WIDTH-1:0] secondary_read_out,
    // axi
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    reg [3:0] quiet;
    default clocking dck @(posedge ref_clk); endclocking
    default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
    // cycles since software traffic, which may move any word behind our back
    always @(posedge ref_clk) begin
        if (rst || s_axi_awvalid || s_axi_wvalid || s_axi_bvalid) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    // clocked write held long enough to clear the synchroniser
    sequence clk_wr;
        $rose(write_clock) && write_enable ##1
        (write_enable && $stable(write_data_in) && $stable(ram_address))[*5];
    endsequence
    en_low_hold_a: assert property (
        (!write_enable && $stable(ram_address) && quiet > 4'h8)[*6]
        |-> $stable(single_port_read_out)) else $error("primary moved with enable low");
    clk_idle_hold_a: assert property (
        (!write_clock && $stable(ram_address) && $stable(secondary_read_address)
        && quiet > 4'h8)[*6] |-> $stable(single_port_read_out) && $stable(secondary_read_out))
        else $error("word moved without write clock");
    wr_shows_a: assert property (
        clk_wr |-> single_port_read_out == write_data_in) else $error("written word not shown");
    shared_store_a: assert property (
        clk_wr ##0 (secondary_read_address == ram_address)
        |-> secondary_read_out == write_data_in) else $error("second port misses write");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rst_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> !s_axi_bvalid && !s_axi_rvalid && single_port_read_out == '0)
        else $error("reset left outputs set");
    cover property (clk_wr);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule

bind pram_top pram_top_asserts #(.DEPTH(DEPTH), .WORD_WIDTH(WORD_WIDTH)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .ram_address(ram_address),
    .secondary_read_address(secondary_read_address), .write_data_in(write_data_in),
    .write_enable(write_enable), .write_clock(write_clock),
    .single_port_read_out(single_port_read_out), .secondary_read_out(secondary_read_out),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ---- verif/pram_user_model.sv ----
/* user logic model that drives the ram pins.
   assumes the caller waits on its tasks; pins change just after ref_clk edges. */
`timescale 1ns/10ps
module pram_user_model #(
    parameter AW = 4,
    parameter WW = 16
) (
    // clock
    input wire ref_clk,
    // ram pins
    output reg [AW-1:0] ram_address,
    output reg [AW-1:0] secondary_read_address,
    output reg [WW-1:0] write_data_in,
    output reg write_enable,
    output reg write_clock
);
    // quiet pins at power-up
    initial begin
        ram_address = '0;
        secondary_read_address = '0;
        write_data_in = '0;
        write_enable = 1'b0;
        write_clock = 1'b0;
    end
////////////////////////////////////////////////////////////////////////////////
    // set addresses and data, then let the pin path settle
    task put(input [AW-1:0] a, input [WW-1:0] d, input [AW-1:0] sa);
        begin
            @(posedge ref_clk);
            ram_address <= a;
            write_data_in <= d;
            secondary_read_address <= sa;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    // one pulse; hold of 3 is the shortest that keeps enable high long enough for the clk_wr sequence to match
    task pulse(input en, input clk, input integer hold);
        begin
            @(posedge ref_clk);
            write_enable <= en;
            repeat (hold) @(posedge ref_clk);
            write_clock <= clk;
            repeat (hold) @(posedge ref_clk);
            write_clock <= 1'b0;
            repeat (hold) @(posedge ref_clk);
            write_enable <= 1'b0;
            // data has no hold duty once enable is low, so scramble it
            write_data_in <= ~write_data_in;
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule

// ---- verif/tb.sv ----
/* self-checking bench for pram_top in its dual-port build.
   assumes the user model drives the ram pins and this bench the axi side. */
`timescale 1ns/10ps
module tb;
    localparam [63:0] FILL = 64'h000000000000C35A;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h00000000;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] addr, sec_addr;
    wire [15:0] wdat, prim_q, sec_q;
    wire wen, wclk;
    integer n_fail = 0, checks = 0, cyc = 0, i;
    reg [31:0] rd;
    reg [1:0] rsp;
    reg [3:0] ta [0:2];
    reg [15:0] td [0:2];

    pram_top #(.VARIANT(2), .DEPTH(16), .WORD_WIDTH(16), .USE_INIT(1), .INIT_FILL(FILL)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .ram_address(addr), .write_data_in(wdat),
        .write_enable(wen), .write_clock(wclk), .secondary_read_address(sec_addr),
        .single_port_read_out(prim_q), .secondary_read_out(sec_q),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pram_user_model u_user (.ref_clk(ref_clk), .ram_address(addr),
        .secondary_read_address(sec_addr), .write_data_in(wdat), .write_enable(wen),
        .write_clock(wclk));
////////////////////////////////////////////////////////////////////////////////
    // 100 ns clock
    always #50 ref_clk = ~ref_clk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // responses are taken late on purpose so the slave must hold them
    task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
        reg da, dw;
        begin
            @(posedge ref_clk);
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= d;
            wvalid <= 1'b1;
            da = 1'b0;
            dw = 1'b0;
            while (!(da && dw)) begin
                @(posedge ref_clk);
                if (awvalid && awready) begin
                    da = 1'b1;
                    awvalid <= 1'b0;
                end
                if (wvalid && wready) begin
                    dw = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            repeat (2) @(posedge ref_clk);
            bready <= 1'b1;
            @(posedge ref_clk);
            while (!bvalid) @(posedge ref_clk);
            r = bresp;
            bready <= 1'b0;
        end
    endtask
    task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge ref_clk);
            araddr <= a;
            arvalid <= 1'b1;
            @(posedge ref_clk);
            while (!arready) @(posedge ref_clk);
            arvalid <= 1'b0;
            repeat (2) @(posedge ref_clk);
            rready <= 1'b1;
            @(posedge ref_clk);
            while (!rvalid) @(posedge ref_clk);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask
////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ta[0] = 4'h0; ta[1] = 4'hF; ta[2] = 4'h5;
        td[0] = 16'h8001; td[1] = 16'h7FFE; td[2] = 16'h1234;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        u_user.put(4'h3, 16'h0000, 4'h3);
        chk("preload", {16'h0000, FILL[15:0]}, {16'h0000, prim_q});
        axi_wr(8'h04, 32'h00000003, rsp);
        chk("addr resp", 32'h00000000, {30'h0, rsp});
        axi_rd(8'h14, rd, rsp);
        chk("sw preload", {16'h0000, FILL[15:0]}, rd);
        axi_rd(8'h20, rd, rsp);
        chk("config", 32'h02100010, rd);
        axi_rd(8'h40, rd, rsp);
        chk("unmapped rd", 32'h00000002, {30'h0, rsp});
        axi_wr(8'h20, 32'h00000000, rsp);
        chk("ro write", 32'h00000002, {30'h0, rsp});
        // boundary and mid addresses back to back, prompt then slow partner
        for (i = 0; i < 3; i = i + 1) begin
            u_user.put(ta[i], td[i], ta[i]);
            u_user.pulse(1'b1, 1'b1, (i == 2) ? 6 : 3);
            chk("written", {16'h0000, td[i]}, {16'h0000, prim_q});
            chk("shared", {16'h0000, td[i]}, {16'h0000, sec_q});
        end
        u_user.put(4'h5, 16'h0BAD, 4'h0);
        u_user.pulse(1'b0, 1'b1, 3);
        chk("en low", {16'h0000, td[2]}, {16'h0000, prim_q});
        chk("second", {16'h0000, td[0]}, {16'h0000, sec_q});
        u_user.put(4'h5, 16'h0BAD, 4'hF);
        u_user.pulse(1'b1, 1'b0, 3);
        chk("no clock", {16'h0000, td[2]}, {16'h0000, prim_q});
        chk("second", {16'h0000, td[1]}, {16'h0000, sec_q});
        u_user.put(4'h3, 16'h0000, 4'h5);
        chk("follow", {16'h0000, FILL[15:0]}, {16'h0000, prim_q});
        chk("second", {16'h0000, td[2]}, {16'h0000, sec_q});
        axi_wr(8'h04, 32'h00000007, rsp);
        axi_wr(8'h08, 32'h0000BEEF, rsp);
        axi_wr(8'h10, 32'h00000001, rsp);
        u_user.put(4'h7, 16'h0000, 4'h7);
        chk("sw write", 32'h0000BEEF, {16'h0000, prim_q});
        // three clocked user writes and one software write, software one last at 7
        axi_rd(8'h1C, rd, rsp);
        chk("status", 32'h00000407, rd);
        rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        u_user.put(4'h5, 16'h0000, 4'h0);
        chk("kept", {16'h0000, td[2]}, {16'h0000, prim_q});
        chk("kept2", {16'h0000, td[0]}, {16'h0000, sec_q});
        tally_and_finish;
    end
endmodule
